// file: hdl/crbt_pkg.sv
// Package of constants and types for the capture/reload/baud timer
package crbt_pkg;

	// APB register byte addresses
	localparam logic [11:0] CRBT_ADDR_CTRL     = 12'h0C8;
	localparam logic [11:0] CRBT_ADDR_COUNT    = 12'h0CC;
	localparam logic [11:0] CRBT_ADDR_RELOAD   = 12'h0D0;
	localparam logic [11:0] CRBT_ADDR_AUX      = 12'h0D4;
	localparam logic [11:0] CRBT_ADDR_INT_STAT = 12'h0D8;
	localparam logic [11:0] CRBT_ADDR_INT_CLR  = 12'h0DC;
	localparam logic [11:0] CRBT_ADDR_INT_EN   = 12'h0E0;

	// Control register field positions
	localparam int CRBT_BIT_OVF  = 7;
	localparam int CRBT_BIT_EXF  = 6;
	localparam int CRBT_BIT_RXS  = 5;
	localparam int CRBT_BIT_TXS  = 4;
	localparam int CRBT_BIT_EXEN = 3;
	localparam int CRBT_BIT_RUN  = 2;
	localparam int CRBT_BIT_CSRC = 1;
	localparam int CRBT_BIT_CPRL = 0;

	// Interrupt status bit positions
	localparam int CRBT_IRQ_OVF = 0;
	localparam int CRBT_IRQ_EXT = 1;

	// Reset values
	localparam logic [7:0]  CRBT_CTRL_RST   = 8'h00;
	localparam logic [15:0] CRBT_COUNT_RST  = 16'h0000;
	localparam logic [15:0] CRBT_RELOAD_RST = 16'h0000;
	localparam logic [1:0]  CRBT_IRQ_RST    = 2'h0;

	// Counter limits
	localparam logic [15:0] CRBT_COUNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CRBT_COUNT_ZERO = 16'h0000;

	// Internal clock divide ratio in core cycles
	localparam int          CRBT_DIV_RATIO = 12;
	localparam logic [3:0]  CRBT_DIV_LAST  = 4'(CRBT_DIV_RATIO - 1);
	localparam logic [3:0]  CRBT_DIV_RST   = 4'h0;

	// Control register layout
	typedef struct packed {
		logic ovf;
		logic exf;
		logic rx_sel;
		logic tx_sel;
		logic exen;
		logic run;
		logic csrc;
		logic cprl;
	} crbt_ctrl_t;

	// Pin event bundle
	typedef struct packed {
		logic trig_fall;
		logic count_fall;
	} crbt_pins_t;

	// Operating modes
	typedef enum logic [1:0] {
		CRBT_MODE_OFF,
		CRBT_MODE_RELOAD,
		CRBT_MODE_CAPTURE,
		CRBT_MODE_BAUD
	} crbt_mode_t;

endpackage : crbt_pkg

// file: hdl/crbt_edge_sync.sv
// Pin synchroniser and falling edge detector
`timescale 1ns/100ps
`default_nettype none
module crbt_edge_sync
	import crbt_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// Pins
	input  wire logic [1:0] pin_in,
	// Falling edge pulses
	output logic      [1:0] fall_out
);

	logic [1:0] meta_r;
	logic [1:0] sync_r;
	logic [1:0] last_r;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					meta_r[g] <= 1'b1;
					sync_r[g] <= 1'b1;
					last_r[g] <= 1'b1;
				end else begin
					meta_r[g] <= pin_in[g];
					sync_r[g] <= meta_r[g];
					last_r[g] <= sync_r[g];
				end
			end
			// Sampled high then sampled low
			assign fall_out[g] = last_r[g] & ~sync_r[g];
		end
	endgenerate

endmodule // crbt_edge_sync
`default_nettype wire

// file: hdl/crbt_timer.sv
// Capture/reload/baud timer with APB register slave
// Behaviour
// - Count divided clock or count pin falls
// - Decode off, reload, capture, baud modes
// - Run control bit 2 starts/stops
// - Overflow sets flag bit 7, not baud
// - Capture mode trigger copies count
// - Trigger enable bit 3 clear ignores pin
// - Auto-reload rollover sets flag, reloads
// - Reload mode trigger forces reload, flag
// - Baud mode trigger: no capture/reload
// - Receive select picks this timer
// - Transmit select picks this timer
// - Baud mode always reloads on overflow
// - Both flags can request interrupts
// - Up/down enable blocks external interrupt
// - Control register resets to zero
`timescale 1ns/100ps
`default_nettype none
module crbt_timer
	import crbt_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_B_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// Pins
	input  wire logic        COUNT_PIN_IN,
	input  wire logic        TRIGGER_PIN_IN,
	// Serial port baud ticks
	input  wire logic        TIMER1_OVF_IN,
	output logic             RX_BAUD_TICK_OUT,
	output logic             TX_BAUD_TICK_OUT,
	// Interrupt
	output logic             IRQ_OUT
);

	crbt_ctrl_t  ctrl_r;
	crbt_ctrl_t  ctrl_nxt;
	crbt_mode_t  mode;
	crbt_pins_t  pins;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [15:0] rld_r;
	logic [15:0] rld_nxt;
	logic [3:0]  div_r;
	logic [1:0]  ist_r;
	logic [1:0]  ien_r;
	logic        udn_r;
	logic        irq_r;
	logic        rx_r;
	logic        tx_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] rdata;
	logic        mapped;
	logic        acc;
	logic        wr;
	logic        wr_ctrl;
	logic        wr_cnt;
	logic        wr_rld;
	logic        wr_aux;
	logic        wr_clr;
	logic        wr_en;
	logic        div_tick;
	logic        cnt_tick;
	logic        ovf;
	logic        baud;
	logic        ext_ev;
	logic        ovf_set;
	logic        exf_set;
	logic [1:0]  fall;

	// Pin synchronisers
	crbt_edge_sync u_sync (
		.clk_in   (CLK_IN),
		.rst_b_in (RST_B_IN),
		.pin_in   ({TRIGGER_PIN_IN, COUNT_PIN_IN}),
		.fall_out (fall)
	);

	assign pins = crbt_pins_t'(fall);

	// APB decode
	assign acc     = PSEL_IN & PENABLE_IN & pready_r;
	assign wr      = acc & PWRITE_IN;
	assign wr_ctrl = wr & (PADDR_IN == CRBT_ADDR_CTRL);
	assign wr_cnt  = wr & (PADDR_IN == CRBT_ADDR_COUNT);
	assign wr_rld  = wr & (PADDR_IN == CRBT_ADDR_RELOAD);
	assign wr_aux  = wr & (PADDR_IN == CRBT_ADDR_AUX);
	assign wr_clr  = wr & (PADDR_IN == CRBT_ADDR_INT_CLR);
	assign wr_en   = wr & (PADDR_IN == CRBT_ADDR_INT_EN);

	// Mode decode
	always_comb begin
		baud = ctrl_r.rx_sel | ctrl_r.tx_sel;
		if (!ctrl_r.run) begin
			mode = CRBT_MODE_OFF;
		end else if (baud) begin
			mode = CRBT_MODE_BAUD;
		end else if (ctrl_r.cprl) begin
			mode = CRBT_MODE_CAPTURE;
		end else begin
			mode = CRBT_MODE_RELOAD;
		end
	end

	// Count source and events
	assign div_tick = (div_r == CRBT_DIV_LAST);
	assign cnt_tick = ctrl_r.run & (ctrl_r.csrc ? pins.count_fall : div_tick);
	assign ovf      = cnt_tick & (cnt_r == CRBT_COUNT_MAX);
	assign ext_ev   = ctrl_r.exen & pins.trig_fall & ctrl_r.run;
	assign ovf_set  = ovf & ~baud;
	assign exf_set  = ext_ev;

	// Internal clock divider
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			div_r <= CRBT_DIV_RST;
		end else if (div_tick) begin
			div_r <= CRBT_DIV_RST;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// Counter next value
	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_cnt) begin
			cnt_nxt = PWDATA_IN[15:0];
		end else if (ext_ev && mode == CRBT_MODE_RELOAD) begin
			cnt_nxt = rld_r;
		end else if (ovf) begin
			if (mode == CRBT_MODE_CAPTURE) begin
				cnt_nxt = CRBT_COUNT_ZERO;
			end else begin
				cnt_nxt = rld_r;
			end
		end else if (cnt_tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			cnt_r <= CRBT_COUNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Reload/capture register
	always_comb begin
		rld_nxt = rld_r;
		if (ext_ev && mode == CRBT_MODE_CAPTURE) begin
			rld_nxt = cnt_r;
		end else if (wr_rld) begin
			rld_nxt = PWDATA_IN[15:0];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rld_r <= CRBT_RELOAD_RST;
		end else begin
			rld_r <= rld_nxt;
		end
	end

	// Control register, hardware set wins over write
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = crbt_ctrl_t'(PWDATA_IN[7:0]);
		end
		if (ovf_set) begin
			ctrl_nxt.ovf = 1'b1;
		end
		if (exf_set) begin
			ctrl_nxt.exf = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_r <= crbt_ctrl_t'(CRBT_CTRL_RST);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Auxiliary up/down enable
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			udn_r <= 1'b0;
		end else if (wr_aux) begin
			udn_r <= PWDATA_IN[0];
		end
	end

	// Interrupt status, enable and output
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ist_r <= CRBT_IRQ_RST;
		end else begin
			ist_r <= (ist_r & ~({2{wr_clr}} & PWDATA_IN[1:0])) | {exf_set, ovf_set};
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ien_r <= CRBT_IRQ_RST;
		end else if (wr_en) begin
			ien_r <= PWDATA_IN[1:0];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (ist_r[CRBT_IRQ_OVF] & ien_r[CRBT_IRQ_OVF])
				| (ist_r[CRBT_IRQ_EXT] & ien_r[CRBT_IRQ_EXT] & ~udn_r);
		end
	end

	// Baud clock selection
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			rx_r <= 1'b0;
			tx_r <= 1'b0;
		end else begin
			rx_r <= ctrl_r.rx_sel ? ovf : TIMER1_OVF_IN;
			tx_r <= ctrl_r.tx_sel ? ovf : TIMER1_OVF_IN;
		end
	end

	// Read mux
	always_comb begin
		rdata  = 32'h0000_0000;
		mapped = 1'b1;
		unique case (PADDR_IN)
			CRBT_ADDR_CTRL:     rdata[7:0]  = ctrl_r;
			CRBT_ADDR_COUNT:    rdata[15:0] = cnt_r;
			CRBT_ADDR_RELOAD:   rdata[15:0] = rld_r;
			CRBT_ADDR_AUX:      rdata[0]    = udn_r;
			CRBT_ADDR_INT_STAT: rdata[1:0]  = ist_r;
			CRBT_ADDR_INT_CLR:  rdata       = 32'h0000_0000;
			CRBT_ADDR_INT_EN:   rdata[1:0]  = ien_r;
			default:            mapped      = 1'b0;
		endcase
	end

	// APB answer, one wait state
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (PSEL_IN && PENABLE_IN && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= ~mapped;
			prdata_r  <= PWRITE_IN ? 32'h0000_0000 : rdata;
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
	end

	assign PRDATA_OUT       = prdata_r;
	assign PREADY_OUT       = pready_r;
	assign PSLVERR_OUT      = pslverr_r;
	assign RX_BAUD_TICK_OUT = rx_r;
	assign TX_BAUD_TICK_OUT = tx_r;
	assign IRQ_OUT          = irq_r;

	// Checks
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);

	property p_count_inc;
		cnt_tick && !ovf && !wr_cnt && !(ext_ev && mode == CRBT_MODE_RELOAD)
			|=> cnt_r == $past(cnt_r) + 16'h0001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter did not advance");

	property p_stop_holds;
		!ctrl_r.run && !wr_cnt |=> cnt_r == $past(cnt_r);
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

	property p_ovf_flag;
		ovf && !baud |=> ctrl_r.ovf && ist_r[CRBT_IRQ_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_baud_no_flag;
		baud && !ctrl_r.ovf && !wr_ctrl |=> !ctrl_r.ovf;
	endproperty
	a_baud_no_flag: assert property (p_baud_no_flag) else $error("overflow flag set in baud mode");

	property p_capture;
		mode == CRBT_MODE_CAPTURE && ext_ev |=> rld_r == $past(cnt_r) && ctrl_r.exf;
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_trig_ignored;
		!ctrl_r.exen && !ctrl_r.exf && !wr_ctrl |=> !ctrl_r.exf;
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger acted while disabled");

	property p_auto_reload;
		ovf && mode != CRBT_MODE_CAPTURE && !wr_cnt |=> cnt_r == $past(rld_r);
	endproperty
	a_auto_reload: assert property (p_auto_reload) else $error("reload on overflow missed");

	property p_trig_reload;
		ext_ev && mode == CRBT_MODE_RELOAD && !wr_cnt |=> cnt_r == $past(rld_r) && ctrl_r.exf;
	endproperty
	a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missed");

	property p_baud_no_capture;
		mode == CRBT_MODE_BAUD && !wr_rld |=> rld_r == $past(rld_r);
	endproperty
	a_baud_no_capture: assert property (p_baud_no_capture) else $error("capture in baud mode");

	property p_rx_select;
		ctrl_r.rx_sel && ovf |=> RX_BAUD_TICK_OUT;
	endproperty
	a_rx_select: assert property (p_rx_select) else $error("receive tick missing");

	property p_tx_source;
		!ctrl_r.tx_sel |=> TX_BAUD_TICK_OUT == $past(TIMER1_OVF_IN);
	endproperty
	a_tx_source: assert property (p_tx_source) else $error("transmit tick source wrong");

	property p_ext_irq_gate;
		udn_r && !(ist_r[CRBT_IRQ_OVF] && ien_r[CRBT_IRQ_OVF]) |=> !IRQ_OUT;
	endproperty
	a_ext_irq_gate: assert property (p_ext_irq_gate) else $error("external irq in up/down mode");

	property p_capture_wrap;
		ovf && mode == CRBT_MODE_CAPTURE && !wr_cnt |=> cnt_r == CRBT_COUNT_ZERO;
	endproperty
	a_capture_wrap: assert property (p_capture_wrap) else $error("capture mode did not wrap");

endmodule // crbt_timer
`default_nettype wire

// file: bench/crbt_serial_model.sv
// Partner model: count and trigger pins, timer 1 and serial baud side
`timescale 1ns/100ps
`default_nettype none
module crbt_serial_model (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// Baud ticks from the timer
	input  wire logic rx_tick_in,
	input  wire logic tx_tick_in,
	// Pins and timer 1 overflow
	output logic      count_pin_out,
	output logic      trig_pin_out,
	output logic      t1_ovf_out
);
	int         n_rx;
	int         n_tx;
	logic [3:0] div_r;

	// Pins idle high on pull-ups
	initial begin
		count_pin_out = 1'b1;
		trig_pin_out = 1'b1;
	end

	// Timer 1 overflow once every 16 cycles
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end
	assign t1_ovf_out = (div_r == 4'hF);

	// Serial side counts baud ticks
	always @(posedge clk_in) begin
		n_rx += int'(rx_tick_in);
		n_tx += int'(tx_tick_in);
	end

	// One falling edge, each level held four cycles
	task automatic fall(input logic trig);
		@(posedge clk_in);
		if (trig)
			trig_pin_out <= 1'b0;
		else
			count_pin_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		trig_pin_out <= 1'b1;
		count_pin_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
endmodule // crbt_serial_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking testbench for the capture/reload/baud timer
`timescale 1ns/100ps
`default_nettype none
module testbench
	import crbt_pkg::*;
;
	localparam logic [11:0] CT = CRBT_ADDR_CTRL;
	localparam logic [11:0] CN = CRBT_ADDR_COUNT;
	localparam logic [11:0] RL = CRBT_ADDR_RELOAD;
	localparam logic [11:0] AX = CRBT_ADDR_AUX;
	localparam logic [11:0] CL = CRBT_ADDR_INT_CLR;

	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} crbt_row_t;

	logic        CLK_IN, RST_B_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
	logic [11:0] PADDR_IN;
	logic [31:0] PWDATA_IN, PRDATA_OUT, rd;
	logic        PREADY_OUT, PSLVERR_OUT, er, COUNT_PIN_IN, TRIGGER_PIN_IN;
	logic        TIMER1_OVF_IN, RX_BAUD_TICK_OUT, TX_BAUD_TICK_OUT, IRQ_OUT;
	int          n_fail, compares, cyc, b_rx, b_tx, k;
	crbt_row_t   rows [6] = '{
		'{RL, 32'hA5C3, 32'hA5C3}, '{CN, 32'h1234, 32'h1234},
		'{AX, 32'h1, 32'h1}, '{CRBT_ADDR_INT_EN, 32'h3, 32'h3},
		'{CL, 32'h3, 32'h0}, '{CRBT_ADDR_INT_STAT, 32'h3, 32'h0}};

	crbt_timer crbt_timer_i (.CLK_IN, .RST_B_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
		.PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .COUNT_PIN_IN,
		.TRIGGER_PIN_IN, .TIMER1_OVF_IN, .RX_BAUD_TICK_OUT, .TX_BAUD_TICK_OUT, .IRQ_OUT);

	crbt_serial_model crbt_serial_model_i (.clk_in(CLK_IN), .rst_b_in(RST_B_IN),
		.rx_tick_in(RX_BAUD_TICK_OUT), .tx_tick_in(TX_BAUD_TICK_OUT),
		.count_pin_out(COUNT_PIN_IN), .trig_pin_out(TRIGGER_PIN_IN), .t1_ovf_out(TIMER1_OVF_IN));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic results();
		$display("n_fail=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// APB transfer, held until ready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		PSEL_IN <= 1'b1;
		PENABLE_IN <= 1'b0;
		PWRITE_IN <= wr;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		@(posedge CLK_IN);
		PENABLE_IN <= 1'b1;
		do begin
			@(posedge CLK_IN);
		end while (PREADY_OUT !== 1'b1);
		rd = PRDATA_OUT;
		er = PSLVERR_OUT;
		PSEL_IN <= 1'b0;
		PENABLE_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask

	task automatic w(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic r(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	initial begin
		CLK_IN = 1'b0;
		forever #5 CLK_IN = ~CLK_IN;
	end

	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		RST_B_IN = 1'b0;
		PSEL_IN = 1'b0;
		PENABLE_IN = 1'b0;
		PWRITE_IN = 1'b0;
		PADDR_IN = 12'h0;
		repeat (16) @(posedge CLK_IN);
		RST_B_IN <= 1'b1;
		@(posedge CLK_IN);
		r(CT);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			w(rows[i].a, rows[i].d);
			r(rows[i].a);
			chk(rd, rows[i].e);
		end
		// Divided clock rolls over and reloads
		w(RL, 32'hAB00);
		w(CN, 32'hFFFD);
		w(CT, 32'h04);
		k = 0;
		while (IRQ_OUT !== 1'b1 && k < 200) begin
			@(posedge CLK_IN);
			k++;
		end
		chk(IRQ_OUT, 32'h1);
		r(CT);
		chk(rd, 32'h84);
		r(CN);
		chk(rd[15:8], 32'hAB);
		w(CT, 32'h0);
		w(CL, 32'h3);
		r(CT);
		chk(rd, 32'h0);
		chk(IRQ_OUT, 32'h0);
		// Capture while counting pin falls
		w(CN, 32'h5000);
		w(CT, 32'h0F);
		repeat (3) crbt_serial_model_i.fall(1'b0);
		crbt_serial_model_i.fall(1'b1);
		r(CN);
		chk(rd, 32'h5003);
		r(RL);
		chk(rd, 32'h5003);
		r(CT);
		chk(rd, 32'h4F);
		chk(IRQ_OUT, 32'h0);
		w(AX, 32'h0);
		@(posedge CLK_IN);
		chk(IRQ_OUT, 32'h1);
		// Capture mode wraps to zero, trigger with enable clear
		w(CN, 32'hFFFF);
		w(CT, 32'h07);
		w(CL, 32'h3);
		crbt_serial_model_i.fall(1'b0);
		r(CN);
		chk(rd, 32'h0);
		crbt_serial_model_i.fall(1'b1);
		r(RL);
		chk(rd, 32'h5003);
		r(CT);
		chk(rd, 32'h87);
		// Trigger forces reload
		w(RL, 32'h1111);
		w(CN, 32'h7777);
		w(CT, 32'h0E);
		crbt_serial_model_i.fall(1'b1);
		r(CN);
		chk(rd, 32'h1111);
		r(CT);
		chk(rd, 32'h4E);
		// Baud mode with capture select set
		w(RL, 32'h2222);
		w(CN, 32'h4444);
		w(CT, 32'h3F);
		crbt_serial_model_i.fall(1'b1);
		r(CN);
		chk(rd, 32'h4444);
		r(RL);
		chk(rd, 32'h2222);
		w(CN, 32'hFFFF);
		b_rx = crbt_serial_model_i.n_rx;
		b_tx = crbt_serial_model_i.n_tx;
		crbt_serial_model_i.fall(1'b0);
		r(CN);
		chk(rd, 32'h2222);
		r(CT);
		chk(rd[7], 32'h0);
		chk(32'(crbt_serial_model_i.n_rx - b_rx), 32'h1);
		chk(32'(crbt_serial_model_i.n_tx - b_tx), 32'h1);
		// Timer 1 drives the ticks when deselected
		w(CT, 32'h0);
		b_rx = crbt_serial_model_i.n_rx;
		b_tx = crbt_serial_model_i.n_tx;
		repeat (40) @(posedge CLK_IN);
		chk(32'(crbt_serial_model_i.n_rx - b_rx > 1), 32'h1);
		chk(32'(crbt_serial_model_i.n_tx - b_tx > 1), 32'h1);
		// Unmapped address
		r(12'h0F0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		// Second reset in mid-run
		w(CT, 32'h3C);
		RST_B_IN <= 1'b0;
		repeat (2) @(posedge CLK_IN);
		RST_B_IN <= 1'b1;
		@(posedge CLK_IN);
		r(CT);
		chk(rd, 32'h0);
		results();
	end
endmodule // testbench
`default_nettype wire
